/* bcr_bridge_ctl.sv */
// Purpose: Capability pointer, interrupt pin and bridge control bits 16..22.
// Assumes: Config cycles arrive already decoded; window bounds come from elsewhere.
// Notes:   Answers and decode results appear one clock after the request.
`default_nettype none

module bcr_bridge_ctl (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire bcr_pkg::bcr_cfg_req_t cfg_req,
  output logic [31:0]               cfg_rdata,
  output logic                      cfg_rvalid,
  input  wire logic                 cmd_serr_en,
  input  wire logic                 cmd_io_en,
  input  wire logic                 cmd_mem_en,
  input  wire logic [31:0]          io_base,
  input  wire logic [31:0]          io_limit,
  input  wire bcr_pkg::bcr_txn_t    pri_txn,
  output logic                      pri_claim,
  input  wire bcr_pkg::bcr_txn_t    sec_txn,
  output logic                      sec_claim,
  input  wire logic                 sec_data_parity_err,
  input  wire logic                 sec_addr_parity_err,
  input  wire logic                 secondary_system_fault_n,
  output logic                      secondary_parity_fault_n,
  output logic                      primary_system_fault_n,
  output logic                      data_parity_reported_set,
  input  wire bcr_pkg::bcr_mabort_t ma_evt,
  output logic                      ma_complete_trdy,
  output logic                      ma_target_abort,
  output logic [31:0]               ma_read_data,
  output logic                      secondary_reset_n
);

  bcr_pkg::bcr_state_t s_q;
  bcr_pkg::bcr_state_t s_d;

  function automatic logic in_io_window(input logic [31:0] a, input logic [31:0] lo,
                                        input logic [31:0] hi);
    in_io_window = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic isa_alias(input logic [31:0] a);
    isa_alias = (a[31:16] == bcr_pkg::BCR_IO_HI_ZERO) && (a[9:8] != bcr_pkg::BCR_ISA_LOW256);
  endfunction

  function automatic logic vga_io_hit(input logic [31:0] a);
    vga_io_hit = (a[31:16] == bcr_pkg::BCR_IO_HI_ZERO) &&
                 (((a[9:0] >= bcr_pkg::BCR_VGA_IO1_LO) && (a[9:0] <= bcr_pkg::BCR_VGA_IO1_HI)) ||
                  ((a[9:0] >= bcr_pkg::BCR_VGA_IO2_LO) && (a[9:0] <= bcr_pkg::BCR_VGA_IO2_HI)));
  endfunction

  function automatic logic vga_mem_hit(input logic [31:0] a);
    vga_mem_hit = (a >= bcr_pkg::BCR_VGA_MEM_LO) && (a <= bcr_pkg::BCR_VGA_MEM_HI);
  endfunction

  logic cfg_rd;
  logic cfg_wr;
  logic ctl_lane;
  logic pri_win;
  logic sec_win;
  logic serr_evt;

  always_comb
  begin
    s_d      = s_q;
    cfg_rd   = cfg_req.valid && !cfg_req.write;
    cfg_wr   = cfg_req.valid && cfg_req.write;
    ctl_lane = !cfg_req.lanes_n[bcr_pkg::BCR_LANE_CTL];
    pri_win  = in_io_window(pri_txn.addr, io_base, io_limit);
    sec_win  = in_io_window(sec_txn.addr, io_base, io_limit);

    // Byte-lane write enable
    // Only the lane holding bits 23:16 carries writable bits here; others are dropped.
    if (cfg_wr && (cfg_req.addr[7:2] == bcr_pkg::BCR_OFF_BRIDGE[7:2]) && ctl_lane)
    begin
      s_d.ctl_perr = cfg_req.wdata[bcr_pkg::BCR_BIT_PERR];
      s_d.ctl_sfwd = cfg_req.wdata[bcr_pkg::BCR_BIT_SFWD];
      s_d.ctl_isa  = cfg_req.wdata[bcr_pkg::BCR_BIT_ISA];
      s_d.ctl_vga  = cfg_req.wdata[bcr_pkg::BCR_BIT_VGA];
      s_d.ctl_mabt = cfg_req.wdata[bcr_pkg::BCR_BIT_MABT];
      s_d.ctl_srst = cfg_req.wdata[bcr_pkg::BCR_BIT_SRST];
    end

    s_d.rvalid = cfg_rd;
    s_d.rdata  = 32'h0000_0000;
    if (cfg_rd && (cfg_req.addr[7:2] == bcr_pkg::BCR_OFF_CAP_PTR[7:2]))
    begin
      s_d.rdata[7:0] = bcr_pkg::BCR_CAP_PTR_VAL;
    end
    else if (cfg_rd && (cfg_req.addr[7:2] == bcr_pkg::BCR_OFF_BRIDGE[7:2]))
    begin
      s_d.rdata[7:0]                   = bcr_pkg::BCR_INT_LIN_VAL;
      s_d.rdata[15:8]                  = bcr_pkg::BCR_INT_PIN_VAL;
      s_d.rdata[bcr_pkg::BCR_BIT_PERR] = s_q.ctl_perr;
      s_d.rdata[bcr_pkg::BCR_BIT_SFWD] = s_q.ctl_sfwd;
      s_d.rdata[bcr_pkg::BCR_BIT_ISA]  = s_q.ctl_isa;
      s_d.rdata[bcr_pkg::BCR_BIT_VGA]  = s_q.ctl_vga;
      s_d.rdata[bcr_pkg::BCR_BIT_MABT] = s_q.ctl_mabt;
      s_d.rdata[bcr_pkg::BCR_BIT_SRST] = s_q.ctl_srst;
    end

    // The fault pin is asynchronous, so it is brought in through two flops first.
    s_d.serr_s1 = secondary_system_fault_n;
    s_d.serr_s2 = s_q.serr_s1;

    s_d.sperr_n = !(sec_data_parity_err && s_q.ctl_perr);
    s_d.dpr_set = sec_data_parity_err && s_q.ctl_perr;

    serr_evt = (s_q.ctl_sfwd && !s_q.serr_s2) ||
               (s_q.ctl_perr && sec_addr_parity_err) ||
               (s_q.ctl_mabt && ma_evt.valid && ma_evt.posted);
    s_d.pserr_n = !(serr_evt && cmd_serr_en);

    s_d.pri_claim = 1'b0;
    if (pri_txn.valid && pri_txn.is_io && cmd_io_en)
    begin
      s_d.pri_claim = (pri_win && !(s_q.ctl_isa && isa_alias(pri_txn.addr))) ||
                      (s_q.ctl_vga && vga_io_hit(pri_txn.addr));
    end
    else if (pri_txn.valid && pri_txn.is_mem && cmd_mem_en)
    begin
      s_d.pri_claim = s_q.ctl_vga && vga_mem_hit(pri_txn.addr);
    end

    // VGA ignored on secondary
    // Memory windows live elsewhere; upstream memory claim here only vetoes VGA space.
    s_d.sec_claim = 1'b0;
    if (sec_txn.valid && sec_txn.is_io)
    begin
      s_d.sec_claim = (!sec_win || (s_q.ctl_isa && isa_alias(sec_txn.addr))) &&
                      !(s_q.ctl_vga && vga_io_hit(sec_txn.addr));
    end
    else if (sec_txn.valid && sec_txn.is_mem)
    begin
      s_d.sec_claim = !(s_q.ctl_vga && vga_mem_hit(sec_txn.addr));
    end

    s_d.ma_trdy   = ma_evt.valid && ma_evt.delayed && !s_q.ctl_mabt;
    s_d.ma_tabort = ma_evt.valid && ma_evt.delayed && s_q.ctl_mabt;
    s_d.ma_rdata  = (ma_evt.valid && ma_evt.delayed && ma_evt.read && !s_q.ctl_mabt) ?
                    bcr_pkg::BCR_ALL_ONES : 32'h0000_0000;

    // Registers kept in reset
    // The secondary reset never feeds back into this state, so software must clear it.
    s_d.srst_n = !s_q.ctl_srst;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_q           <= '0;
      s_q.ctl_perr  <= bcr_pkg::BCR_CTL_RESET;
      s_q.ctl_sfwd  <= bcr_pkg::BCR_CTL_RESET;
      s_q.ctl_isa   <= bcr_pkg::BCR_CTL_RESET;
      s_q.ctl_vga   <= bcr_pkg::BCR_CTL_RESET;
      s_q.ctl_mabt  <= bcr_pkg::BCR_CTL_RESET;
      s_q.ctl_srst  <= bcr_pkg::BCR_CTL_RESET;
      s_q.serr_s1   <= 1'b1;
      s_q.serr_s2   <= 1'b1;
      s_q.pserr_n   <= 1'b1;
      s_q.sperr_n   <= 1'b1;
      s_q.srst_n    <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign cfg_rdata                = s_q.rdata;
  assign cfg_rvalid               = s_q.rvalid;
  assign pri_claim                = s_q.pri_claim;
  assign sec_claim                = s_q.sec_claim;
  assign secondary_parity_fault_n = s_q.sperr_n;
  assign primary_system_fault_n   = s_q.pserr_n;
  assign data_parity_reported_set = s_q.dpr_set;
  assign ma_complete_trdy         = s_q.ma_trdy;
  assign ma_target_abort          = s_q.ma_tabort;
  assign ma_read_data             = s_q.ma_rdata;
  assign secondary_reset_n        = s_q.srst_n;

  a_cap_ptr_read: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg_req.valid && !cfg_req.write && cfg_req.addr[7:2] == 6'h0D) |=>
      (cfg_rvalid && cfg_rdata == 32'h0000_00DC))
    else $error("Capability pointer read wrong.");

  a_int_pin_rsvd: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg_req.valid && !cfg_req.write && cfg_req.addr[7:2] == 6'h0F) |=>
      (cfg_rdata[15:8] == 8'h00 && cfg_rdata[20] == 1'b0 && cfg_rdata[31:23] == 9'h000))
    else $error("Interrupt pin or reserved bits not zero.");

  a_perr_gated: assert property (@(posedge clk) disable iff (!rst_n)
    (!s_q.ctl_perr) |=> (secondary_parity_fault_n && !data_parity_reported_set))
    else $error("Parity reported while response is off.");

  a_perr_driven: assert property (@(posedge clk) disable iff (!rst_n)
    (sec_data_parity_err && s_q.ctl_perr) |=>
      (!secondary_parity_fault_n && data_parity_reported_set))
    else $error("Parity fault not driven.");

  a_serr_forward: assert property (@(posedge clk) disable iff (!rst_n)
    (!secondary_system_fault_n && s_q.ctl_sfwd && cmd_serr_en)[*3] |=> !primary_system_fault_n)
    else $error("Secondary system fault not forwarded.");

  a_serr_needs_en: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(primary_system_fault_n) |-> $past(cmd_serr_en))
    else $error("System fault raised without enable.");

  a_isa_filter: assert property (@(posedge clk) disable iff (!rst_n)
    (pri_txn.valid && pri_txn.is_io && s_q.ctl_isa && !s_q.ctl_vga &&
     pri_txn.addr[31:16] == 16'h0000 && pri_txn.addr[9:8] != 2'h0) |=> !pri_claim)
    else $error("ISA alias claimed on primary.");

  a_vga_mem_claim: assert property (@(posedge clk) disable iff (!rst_n)
    (pri_txn.valid && pri_txn.is_mem && !pri_txn.is_io && cmd_mem_en && s_q.ctl_vga &&
     pri_txn.addr >= 32'h000A_0000 && pri_txn.addr <= 32'h000B_FFFF) |=> pri_claim)
    else $error("VGA memory not claimed.");

  a_vga_sec_ignore: assert property (@(posedge clk) disable iff (!rst_n)
    (sec_txn.valid && sec_txn.is_mem && !sec_txn.is_io && s_q.ctl_vga &&
     sec_txn.addr >= 32'h000A_0000 && sec_txn.addr <= 32'h000B_FFFF) |=> !sec_claim)
    else $error("VGA memory forwarded upstream.");

  a_mabort_mode: assert property (@(posedge clk) disable iff (!rst_n)
    (ma_evt.valid && ma_evt.delayed) |=>
      (ma_target_abort == $past(s_q.ctl_mabt) && ma_complete_trdy == !$past(s_q.ctl_mabt)))
    else $error("Master abort completion wrong.");

  a_sec_reset: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg_req.valid && cfg_req.write && cfg_req.addr[7:2] == 6'h0F && !cfg_req.lanes_n[2])
      |=> ##1 (secondary_reset_n == !$past(cfg_req.wdata[22], 2)))
    else $error("Secondary reset does not follow control bit.");

  a_win_forward: assert property (@(posedge clk) disable iff (!rst_n)
    (pri_txn.valid && pri_txn.is_io && cmd_io_en && !s_q.ctl_isa &&
     pri_txn.addr >= io_base && pri_txn.addr <= io_limit) |=> pri_claim)
    else $error("Window I/O not forwarded downstream.");

  a_isa_upstream: assert property (@(posedge clk) disable iff (!rst_n)
    (sec_txn.valid && sec_txn.is_io && s_q.ctl_isa && !s_q.ctl_vga &&
     sec_txn.addr[31:16] == 16'h0000 && sec_txn.addr[9:8] != 2'h0) |=> sec_claim)
    else $error("ISA alias not forwarded upstream.");

  a_vga_io_claim: assert property (@(posedge clk) disable iff (!rst_n)
    (pri_txn.valid && pri_txn.is_io && cmd_io_en && s_q.ctl_vga &&
     pri_txn.addr[31:16] == 16'h0000 &&
     ((pri_txn.addr[9:0] >= 10'h3B0 && pri_txn.addr[9:0] <= 10'h3BB) ||
      (pri_txn.addr[9:0] >= 10'h3C0 && pri_txn.addr[9:0] <= 10'h3DF))) |=> pri_claim)
    else $error("VGA I/O not claimed.");

  a_abort_ones: assert property (@(posedge clk) disable iff (!rst_n)
    (ma_evt.valid && ma_evt.delayed && ma_evt.read && !s_q.ctl_mabt) |=>
      (ma_read_data == 32'hFFFF_FFFF))
    else $error("Aborted read did not return all ones.");

  a_ctl_reset: assert property (@(posedge clk)
    !rst_n |=> (secondary_reset_n && primary_system_fault_n && secondary_parity_fault_n &&
                !cfg_rvalid && cfg_rdata == 32'h0000_0000))
    else $error("Outputs not at reset values after reset.");

endmodule : bcr_bridge_ctl

`default_nettype wire

/* bcr_pkg.sv */
// Purpose: Shared constants and carrier types for the bridge control register slice.
// Assumes: One clock domain, synchronous active-low reset.
// Notes:   Configuration offsets are byte addresses of aligned dwords.
`default_nettype none

package bcr_pkg;

  // Dword offsets decoded by this slice.
  localparam logic [7:0] BCR_OFF_CAP_PTR = 8'h34;
  localparam logic [7:0] BCR_OFF_BRIDGE  = 8'h3C;

  // Fixed read values.
  localparam logic [7:0] BCR_CAP_PTR_VAL = 8'hDC;
  localparam logic [7:0] BCR_INT_PIN_VAL = 8'h00;
  localparam logic [7:0] BCR_INT_LIN_VAL = 8'h00;

  // Bridge control field positions inside the 0x3C dword.
  localparam int BCR_BIT_PERR  = 16;
  localparam int BCR_BIT_SFWD  = 17;
  localparam int BCR_BIT_ISA   = 18;
  localparam int BCR_BIT_VGA   = 19;
  localparam int BCR_BIT_RSVD  = 20;
  localparam int BCR_BIT_MABT  = 21;
  localparam int BCR_BIT_SRST  = 22;
  localparam int BCR_LANE_CTL  = 2;

  // Value of every writable control bit after reset.
  localparam logic BCR_CTL_RESET = 1'b0;

  // Address ranges used by the forwarding decode.
  localparam logic [31:0] BCR_VGA_MEM_LO = 32'h000A_0000;
  localparam logic [31:0] BCR_VGA_MEM_HI = 32'h000B_FFFF;
  localparam logic [9:0]  BCR_VGA_IO1_LO = 10'h3B0;
  localparam logic [9:0]  BCR_VGA_IO1_HI = 10'h3BB;
  localparam logic [9:0]  BCR_VGA_IO2_LO = 10'h3C0;
  localparam logic [9:0]  BCR_VGA_IO2_HI = 10'h3DF;
  localparam logic [15:0] BCR_IO_HI_ZERO = 16'h0000;
  localparam logic [1:0]  BCR_ISA_LOW256 = 2'h0;
  localparam logic [31:0] BCR_ALL_ONES   = 32'hFFFF_FFFF;

  // Configuration access from the primary interface.
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  addr;
    logic [3:0]  lanes_n;
    logic [31:0] wdata;
  } bcr_cfg_req_t;

  // One transaction offered to the forwarding decode.
  typedef struct packed {
    logic        valid;
    logic        is_io;
    logic        is_mem;
    logic [31:0] addr;
  } bcr_txn_t;

  // Master-abort report from the transaction engine.
  typedef struct packed {
    logic valid;
    logic delayed;
    logic read;
    logic posted;
  } bcr_mabort_t;

  // Whole state of the slice.
  typedef struct packed {
    logic        ctl_perr;
    logic        ctl_sfwd;
    logic        ctl_isa;
    logic        ctl_vga;
    logic        ctl_mabt;
    logic        ctl_srst;
    logic [31:0] rdata;
    logic        rvalid;
    logic        serr_s1;
    logic        serr_s2;
    logic        pserr_n;
    logic        sperr_n;
    logic        dpr_set;
    logic        pri_claim;
    logic        sec_claim;
    logic        ma_trdy;
    logic        ma_tabort;
    logic [31:0] ma_rdata;
    logic        srst_n;
  } bcr_state_t;

endpackage : bcr_pkg

`default_nettype wire

/* bcr_sec_agent.sv */
// Purpose: Secondary-side agent raising parity and system fault events.
// Assumes: The bench calls its tasks; changes land on the falling edge.
// Notes:   The fault pin is a level, parity errors are one-clock events.
`default_nettype none

module bcr_sec_agent (
  input  wire logic clk,
  output logic      fault_n,
  output logic      data_err,
  output logic      addr_err
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    fault_n = 1'b1;
    data_err = 1'b0;
    addr_err = 1'b0;
  end

  task automatic set_fault(input logic low);
    @(negedge clk);
    fault_n = !low;
  endtask

  task automatic pulse(input logic d, input logic a);
    @(negedge clk);
    data_err = d;
    addr_err = a;
    @(negedge clk);
    data_err = 1'b0;
    addr_err = 1'b0;
  endtask
endmodule // bcr_sec_agent

`default_nettype wire

/* tb_top.sv */
// Purpose: Self-checking bench for the bridge control register slice.
// Assumes: Inputs change on the falling edge; answers come one clock later.
// Notes:   The I/O window is fixed at 0x1000..0x1FFF for every decode test.
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic                  clk, rst_n, serr_en, io_en, mem_en;
  logic                  rvalid, pclaim, sclaim, spf_n, ppf_n, dpr, trdy, tabt, srst_n;
  logic                  sfault_n, dpe, ape;
  logic [31:0]           rdata, mrd, base, limit;
  bcr_pkg::bcr_cfg_req_t req;
  bcr_pkg::bcr_txn_t     pri, sec;
  bcr_pkg::bcr_mabort_t  ma;
  int                    miscompares, checked;

  bcr_bridge_ctl i_dut (.clk(clk), .rst_n(rst_n), .cfg_req(req), .cfg_rdata(rdata),
    .cfg_rvalid(rvalid), .cmd_serr_en(serr_en), .cmd_io_en(io_en), .cmd_mem_en(mem_en),
    .io_base(base), .io_limit(limit), .pri_txn(pri), .pri_claim(pclaim), .sec_txn(sec),
    .sec_claim(sclaim), .sec_data_parity_err(dpe), .sec_addr_parity_err(ape),
    .secondary_system_fault_n(sfault_n), .secondary_parity_fault_n(spf_n),
    .primary_system_fault_n(ppf_n), .data_parity_reported_set(dpr), .ma_evt(ma),
    .ma_complete_trdy(trdy), .ma_target_abort(tabt), .ma_read_data(mrd),
    .secondary_reset_n(srst_n));
  bcr_sec_agent i_sec (.clk(clk), .fault_n(sfault_n), .data_err(dpe), .addr_err(ape));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_bit(input string n, input logic e, input logic g);
    checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic cfg(input logic w, input logic [7:0] a, input logic [3:0] ln,
                     input logic [31:0] d);
    @(negedge clk);
    req = '{valid: 1'b1, write: w, addr: a, lanes_n: ln, wdata: d};
    @(negedge clk);
    req.valid = 1'b0;
    if (!w)
    begin
      chk_bit("cfg_rvalid", 1'b1, rvalid);
      chk_word("cfg_rdata", d, rdata);
    end
    else
    begin
      chk_bit("cfg_rvalid", 1'b0, rvalid);
    end
  endtask

  // Bit 6 of b is control bit 22, bit 0 is control bit 16.
  task automatic ctl(input logic [6:0] b);
    cfg(1'b1, 8'h3C, 4'hB, {9'h000, b, 16'h0000});
  endtask

  task automatic offer(input logic s, input logic io, input logic [31:0] a, input logic e);
    @(negedge clk);
    if (s)
      sec = '{valid: 1'b1, is_io: io, is_mem: !io, addr: a};
    else
      pri = '{valid: 1'b1, is_io: io, is_mem: !io, addr: a};
    @(negedge clk);
    pri.valid = 1'b0;
    sec.valid = 1'b0;
    chk_bit(s ? "sec_claim" : "pri_claim", e, s ? sclaim : pclaim);
  endtask

  task automatic abort(input logic rd, input logic dly, input logic et, input logic ea,
                       input logic ep, input logic [31:0] ed);
    @(negedge clk);
    ma = '{valid: 1'b1, delayed: dly, read: rd, posted: !dly};
    @(negedge clk);
    ma.valid = 1'b0;
    chk_bit("ma_complete_trdy", et, trdy);
    chk_bit("ma_target_abort", ea, tabt);
    chk_bit("primary_system_fault_n", ep, ppf_n);
    chk_word("ma_read_data", ed, mrd);
  endtask

  task automatic wrap_up();
    $display("checks %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    repeat (2000) @(posedge clk);
    miscompares++;
    wrap_up();
  end

  initial
  begin
    rst_n = 1'b0;
    req = '0;
    pri = '0;
    sec = '0;
    ma = '0;
    {serr_en, io_en, mem_en} = 3'b111;
    base = 32'h0000_1000;
    limit = 32'h0000_1FFF;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    chk_bit("secondary_reset_n", 1'b1, srst_n);
    cfg(1'b0, 8'h34, 4'h0, 32'h0000_00DC);
    cfg(1'b0, 8'h3C, 4'h0, 32'h0000_0000);
    cfg(1'b1, 8'h34, 4'h0, 32'hFFFF_FFFF);
    cfg(1'b0, 8'h34, 4'h0, 32'h0000_00DC);
    cfg(1'b1, 8'h3C, 4'h4, 32'hFFFF_FFFF);
    cfg(1'b0, 8'h3C, 4'h0, 32'h0000_0000);
    cfg(1'b1, 8'h3C, 4'h0, 32'hFFFF_FFFF);
    cfg(1'b0, 8'h3C, 4'h0, 32'h006F_0000);
    chk_bit("secondary_reset_n", 1'b0, srst_n);
    cfg(1'b0, 8'h3C, 4'h0, 32'h006F_0000);
    ctl(7'h00);
    cfg(1'b0, 8'h3C, 4'h0, 32'h0000_0000);
    chk_bit("secondary_reset_n", 1'b1, srst_n);
    ctl(7'h7F);
    @(negedge clk);
    chk_bit("secondary_reset_n", 1'b0, srst_n);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    chk_bit("secondary_reset_n", 1'b1, srst_n);
    cfg(1'b0, 8'h3C, 4'h0, 32'h0000_0000);
    $display("test registers done");
    offer(1'b0, 1'b1, 32'h0000_1100, 1'b1);
    offer(1'b1, 1'b1, 32'h0000_1100, 1'b0);
    offer(1'b0, 1'b1, 32'h0000_03C0, 1'b0);
    ctl(7'h04);
    offer(1'b0, 1'b1, 32'h0000_1100, 1'b0);
    offer(1'b0, 1'b1, 32'h0000_1000, 1'b1);
    offer(1'b1, 1'b1, 32'h0000_1100, 1'b1);
    ctl(7'h08);
    offer(1'b0, 1'b1, 32'h0000_03C0, 1'b1);
    offer(1'b0, 1'b1, 32'h0000_07BB, 1'b1);
    offer(1'b0, 1'b1, 32'h0000_03BC, 1'b0);
    offer(1'b0, 1'b1, 32'h0001_03C0, 1'b0);
    offer(1'b0, 1'b0, 32'h000A_0000, 1'b1);
    offer(1'b0, 1'b0, 32'h000B_FFFF, 1'b1);
    offer(1'b0, 1'b0, 32'h000C_0000, 1'b0);
    offer(1'b1, 1'b1, 32'h0000_03C0, 1'b0);
    offer(1'b1, 1'b0, 32'h000A_0000, 1'b0);
    offer(1'b1, 1'b0, 32'h000C_0000, 1'b1);
    {io_en, mem_en} = 2'b00;
    offer(1'b0, 1'b1, 32'h0000_03C0, 1'b0);
    offer(1'b0, 1'b0, 32'h000A_0000, 1'b0);
    {io_en, mem_en} = 2'b11;
    $display("test decode done");
    ctl(7'h00);
    i_sec.pulse(1'b1, 1'b1);
    chk_bit("secondary_parity_fault_n", 1'b1, spf_n);
    chk_bit("data_parity_reported_set", 1'b0, dpr);
    chk_bit("primary_system_fault_n", 1'b1, ppf_n);
    ctl(7'h01);
    i_sec.pulse(1'b1, 1'b0);
    chk_bit("secondary_parity_fault_n", 1'b0, spf_n);
    chk_bit("data_parity_reported_set", 1'b1, dpr);
    i_sec.pulse(1'b0, 1'b1);
    chk_bit("primary_system_fault_n", 1'b0, ppf_n);
    ctl(7'h02);
    i_sec.set_fault(1'b1);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk_bit("primary_system_fault_n", 1'b0, ppf_n);
    i_sec.set_fault(1'b0);
    repeat (4) @(negedge clk);
    ctl(7'h00);
    i_sec.set_fault(1'b1);
    repeat (4) @(negedge clk);
    chk_bit("primary_system_fault_n", 1'b1, ppf_n);
    i_sec.set_fault(1'b0);
    $display("test faults done");
    abort(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 32'hFFFF_FFFF);
    abort(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 32'h0000_0000);
    abort(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 32'h0000_0000);
    ctl(7'h20);
    abort(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 32'h0000_0000);
    abort(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 32'h0000_0000);
    $display("test master_abort done");
    wrap_up();
  end
endmodule // tb_top

`default_nettype wire
